// ---- rbsdm_pkg.sv ----
// Shared constants and types for the reading buffer and measurement sequencer
package rbsdm_pkg;
  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_MHZ = 250;
  localparam int SD_STEP_NS = 10_000; // Source delay step
  localparam int SD_STEP_CYC = SD_STEP_NS * CLK_MHZ / 1000;
  localparam int SD_DEF_US = 1000; // Source delay after reset
  localparam logic [23:0] SD_DEF_STEPS = 24'(SD_DEF_US * 1000 / SD_STEP_NS);
  localparam int SD_MAX_S = 99;
  localparam logic [23:0] SD_MAX_STEPS = 24'(SD_MAX_S * (1_000_000_000 / SD_STEP_NS));
  localparam int OD_UNIT_NS = 1_000_000; // Output delay counts in milliseconds
  localparam int OD_UNIT_CYC = OD_UNIT_NS / 1000 * CLK_MHZ;
  localparam logic [13:0] OD_MIN_MS = 14'h0001;
  localparam logic [13:0] OD_MAX_MS = 14'h2710;
  localparam int SLEW_TICK_NS = 1000; // Slew step period, rate in V/s is uV per tick
  localparam int SLEW_TICK_CYC = SLEW_TICK_NS * CLK_MHZ / 1000;
  localparam logic [9:0] SLEW_MIN = 10'h00a;
  localparam logic [9:0] SLEW_MAX = 10'h3e8;

  // ********************************************************************
  // Buffer and functions
  // ********************************************************************
  localparam int CAP_MAX = 2500;
  localparam int CW = 12;
  localparam int IW = 24;
  localparam int VW = 24;
  localparam int STW = 8;
  localparam int SETW = 25;
  localparam logic [11:0] CAP_PSU_RST = 12'h064;
  localparam logic [11:0] CAP_BATT = 12'h9c4;
  localparam logic [1:0] FN_PSU = 2'h0;
  localparam logic [1:0] FN_BTEST = 2'h1;
  localparam logic [1:0] FN_BSIM = 2'h2;
  localparam logic [2:0] RES_5P5 = 3'h2;
  localparam logic [2:0] RES_6P5 = 3'h3;

  typedef enum logic [1:0] {FILL_NEVER, FILL_NEXT, FILL_ALWAYS} rbsdm_fill_t;
endpackage

// ---- rbsdm_stat_if.sv ----
// Carrier between the buffer control and the statistics engine
`timescale 1ns/1ps
`default_nettype none
interface rbsdm_stat_if #(
  parameter int VW = 24,
  parameter int CW = 12
);
  logic clr;
  logic upd;
  logic drop;
  logic signed [VW-1:0] new_v;
  logic signed [VW-1:0] old_v;
  logic [CW-1:0] n;
  logic signed [VW-1:0] avg;
  logic signed [VW-1:0] vmin;
  logic signed [VW-1:0] vmax;
  logic [VW:0] p2p;
  logic [VW-1:0] std;
  logic busy;
  modport eng (input clr, upd, drop, new_v, old_v, n,
               output avg, vmin, vmax, p2p, std, busy);
  modport ctl (output clr, upd, drop, new_v, old_v, n,
               input avg, vmin, vmax, p2p, std, busy);
endinterface
`default_nettype wire

// ---- rbsdm_stats.sv ----
// Running statistics over stored voltage readings
`timescale 1ns/1ps
`default_nettype none
module rbsdm_stats #(
  parameter int VW = 24,
  parameter int CW = 12
) (
  input wire logic mclk,
  input wire logic rst,
  rbsdm_stat_if.eng s
);
  import rbsdm_pkg::*;
  localparam int SW = VW + CW;
  localparam int QW = 2 * VW + CW;
  typedef enum logic [1:0] {ST_IDLE, ST_DSUM, ST_DSQ, ST_ROOT} rbsdm_sph_t;
  typedef struct packed {
    rbsdm_sph_t ph;
    logic [5:0] it;
    logic signed [SW-1:0] sum;
    logic [QW-1:0] sq;
    logic have;
    logic signed [VW-1:0] vmin;
    logic signed [VW-1:0] vmax;
    logic [VW:0] p2p;
    logic neg;
    logic [QW-1:0] num;
    logic [CW:0] rem;
    logic [VW-1:0] mag;
    logic [2*VW-1:0] var_v;
    logic [VW-1:0] root;
    logic signed [VW-1:0] avg;
    logic [VW-1:0] std;
  } rbsdm_sst_t;
  rbsdm_sst_t q, next_q;
  logic [CW:0] rem_sh;
  logic div_bit;
  logic [VW-1:0] trial;
  logic [2*VW-1:0] trial_sq;
  logic signed [2*VW-1:0] nv, ov;
  logic signed [SW-1:0] sum_n;
  logic [2*VW-1:0] msq;
  logic [2*VW-1:0] mag_sq;

  // Update sums, then mean by long division, mean square, and square root
  always_comb begin
    next_q = q;
    rem_sh = {q.rem[CW-1:0], q.num[QW-1]};
    div_bit = rem_sh >= {1'b0, s.n};
    trial = q.root | (VW'(1) << q.it);
    trial_sq = trial * trial;
    nv = (2*VW)'(s.new_v);
    ov = (2*VW)'(s.old_v);
    sum_n = q.sum + SW'(s.new_v) - (s.drop ? SW'(s.old_v) : SW'(0));
    msq = q.num[2*VW-1:0];
    mag_sq = q.mag * q.mag;
    next_q.p2p = (VW+1)'(q.vmax) - (VW+1)'(q.vmin);
    if (s.clr) begin
      next_q.sum = '0;
      next_q.sq = '0;
      next_q.have = 1'b0;
      next_q.vmin = '0;
      next_q.vmax = '0;
      next_q.avg = '0;
      next_q.std = '0;
      next_q.ph = ST_IDLE;
    end else if (s.upd) begin
      next_q.sum = sum_n;
      next_q.sq = q.sq + QW'($unsigned(nv * nv)) - (s.drop ? QW'($unsigned(ov * ov)) : QW'(0));
      next_q.have = 1'b1;
      next_q.vmin = (!q.have || s.new_v < q.vmin) ? s.new_v : q.vmin;
      next_q.vmax = (!q.have || s.new_v > q.vmax) ? s.new_v : q.vmax;
      next_q.neg = sum_n[SW-1];
      next_q.num = QW'(sum_n[SW-1] ? -sum_n : sum_n);
      next_q.rem = '0;
      next_q.it = 6'(QW - 1);
      next_q.ph = ST_DSUM;
    end else begin
      case (q.ph)
        ST_DSUM, ST_DSQ: begin
          next_q.num = {q.num[QW-2:0], div_bit};
          next_q.rem = div_bit ? rem_sh - {1'b0, s.n} : rem_sh;
          next_q.it = q.it - 6'h01;
          if (q.it == 6'h00 && q.ph == ST_DSUM) begin
            next_q.mag = next_q.num[VW-1:0];
            next_q.avg = q.neg ? -next_q.num[VW-1:0] : next_q.num[VW-1:0];
            next_q.num = q.sq;
            next_q.rem = '0;
            next_q.it = 6'(QW - 1);
            next_q.ph = ST_DSQ;
          end else if (q.it == 6'h00) begin
            next_q.it = 6'(QW - 1);
            next_q.ph = ST_ROOT;
          end
        end
        ST_ROOT: begin
          if (q.it == 6'(QW - 1)) begin
            next_q.var_v = (msq > mag_sq) ? msq - mag_sq : '0;
            next_q.root = '0;
            next_q.it = 6'(VW - 1);
          end else begin
            if (trial_sq <= q.var_v) begin
              next_q.root = trial;
            end
            next_q.it = q.it - 6'h01;
            if (q.it == 6'h00) begin
              next_q.std = (trial_sq <= q.var_v) ? trial : q.root;
              next_q.ph = ST_IDLE;
            end
          end
        end
        default: next_q.ph = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Results straight from state
  assign s.avg = q.avg;
  assign s.vmin = q.vmin;
  assign s.vmax = q.vmax;
  assign s.p2p = q.p2p;
  assign s.std = q.std;
  assign s.busy = q.ph != ST_IDLE;
endmodule
`default_nettype wire

// ---- rbsdm_top.sv ----
// Reading buffer, source-delay-measure sequencer, output delay and slew limiter
`timescale 1ns/1ps
`default_nettype none
module rbsdm_top #(
  parameter int DEPTH = rbsdm_pkg::CAP_MAX,
  parameter int IW = rbsdm_pkg::IW,
  parameter int VW = rbsdm_pkg::VW,
  parameter int STW = rbsdm_pkg::STW,
  parameter int OD_CYC = rbsdm_pkg::OD_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] fn_sel,
  input wire logic fill_mode_wr,
  input wire rbsdm_pkg::rbsdm_fill_t fill_mode_in,
  input wire logic auto_clear_en,
  input wire logic buf_clear,
  input wire logic cap_wr,
  input wire logic [rbsdm_pkg::CW-1:0] cap_in,
  input wire logic rdg_valid,
  input wire logic signed [IW-1:0] rdg_current,
  input wire logic signed [VW-1:0] rdg_voltage,
  input wire logic [STW-1:0] rdg_status,
  input wire logic [rbsdm_pkg::CW-1:0] rd_idx,
  output logic [IW+VW+STW:0] rd_data,
  input wire logic sd_wr,
  input wire logic sd_en_in,
  input wire logic [23:0] sd_steps_in,
  input wire logic res_wr,
  input wire logic [2:0] res_in,
  input wire logic od_en,
  input wire logic [13:0] od_rise_ms,
  input wire logic [13:0] od_fall_ms,
  input wire logic out_req,
  input wire logic [9:0] slew_rise,
  input wire logic [9:0] slew_fall,
  input wire logic [rbsdm_pkg::SETW-1:0] vset_in,
  input wire logic sdm_start,
  output logic out_en,
  output logic [rbsdm_pkg::SETW-1:0] vset_out,
  output logic meas_start,
  output logic sdm_busy,
  output rbsdm_pkg::rbsdm_fill_t fill_mode,
  output logic [rbsdm_pkg::CW-1:0] buf_count,
  output logic [rbsdm_pkg::CW-1:0] buf_cap,
  output logic buf_full,
  output logic sd_en,
  output logic [23:0] sd_steps,
  output logic signed [VW-1:0] stat_avg,
  output logic signed [VW-1:0] stat_min,
  output logic signed [VW-1:0] stat_max,
  output logic [VW:0] stat_p2p,
  output logic [VW-1:0] stat_std,
  output logic stat_busy
);
  import rbsdm_pkg::*;
  localparam int EW = IW + VW + STW + 1;
  localparam int ODPW = $clog2(OD_CYC) + 1;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {SQ_IDLE, SQ_APPLY, SQ_DELAY} rbsdm_sdm_t;
  typedef struct packed {
    rbsdm_fill_t mode;
    logic [CW-1:0] cap_psu;
    logic [CW-1:0] cap;
    logic [CW-1:0] wptr;
    logic [CW-1:0] count;
    logic full;
    logic sd_en;
    logic [23:0] sd_steps;
    rbsdm_sdm_t source_delay_measure_cycle;
    logic [11:0] sd_pre;
    logic [23:0] sd_cnt;
    logic meas_start;
    logic sdm_busy;
    logic out_en;
    logic [ODPW-1:0] od_pre;
    logic [13:0] od_cnt;
    logic [SETW-1:0] vset;
    logic [SETW-1:0] target;
    logic [7:0] tick;
  } rbsdm_st_t;
  rbsdm_st_t q, next_q;

  logic [EW-1:0] mem [DEPTH];
  logic is_psu;
  rbsdm_fill_t mode_eff;
  logic clr;
  logic accept;
  logic drop;
  logic [CW-1:0] cap_n;
  logic [CW:0] rd_sum;
  logic [CW-1:0] rd_phys;
  logic [13:0] od_lim;
  logic [9:0] rate;
  logic [SETW-1:0] diff;

  rbsdm_stat_if #(.VW(VW), .CW(CW)) st ();

  // Clamp a programmed value into its legal range
  function automatic logic [13:0] rbsdm_clamp(input logic [13:0] v, input logic [13:0] lo,
                                              input logic [13:0] hi);
    rbsdm_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Function qualifiers and reading acceptance
  always_comb begin
    is_psu = fn_sel == FN_PSU;
    mode_eff = is_psu ? q.mode : FILL_ALWAYS;
    cap_n = is_psu ? q.cap_psu : CAP_BATT;
    if (is_psu && cap_wr) begin
      cap_n = (cap_in == '0) ? CW'(1) : ((cap_in > CW'(DEPTH)) ? CW'(DEPTH) : cap_in);
    end
    clr = buf_clear || (cap_n != q.cap)
          || (is_psu && fill_mode_wr && auto_clear_en && fill_mode_in != FILL_NEVER);
    accept = rdg_valid && !clr && mode_eff != FILL_NEVER
             && (mode_eff == FILL_ALWAYS || q.count < q.cap);
    drop = accept && q.count == q.cap;
    rd_sum = {1'b0, q.wptr} + {1'b0, rd_idx};
    if (drop || (mode_eff == FILL_ALWAYS && q.count == q.cap)) begin
      rd_phys = (rd_sum >= {1'b0, q.cap}) ? CW'(rd_sum - {1'b0, q.cap}) : rd_sum[CW-1:0];
    end else begin
      rd_phys = rd_idx;
    end
  end

  // Statistics engine hookup
  assign st.clr = clr;
  assign st.upd = accept;
  assign st.drop = drop;
  assign st.new_v = rdg_voltage;
  assign st.old_v = mem[q.wptr][STW+1 +: VW];
  assign st.n = q.count; // Divisor is the count after the accepting edge

  rbsdm_stats #(.VW(VW), .CW(CW)) u_stats (
    .mclk(mclk),
    .rst(rst),
    .s(st.eng)
  );

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    next_q = q;
    od_lim = '0;
    rate = '0;
    diff = '0;
    next_q.meas_start = 1'b0;

    // Buffer capacity and fill mode
    next_q.cap = cap_n;
    if (is_psu && cap_wr) begin
      next_q.cap_psu = cap_n;
    end
    if (accept) begin
      next_q.wptr = (q.wptr == q.cap - CW'(1)) ? '0 : q.wptr + CW'(1);
      next_q.count = (q.count == q.cap) ? q.count : q.count + CW'(1);
      if (mode_eff == FILL_NEXT && q.count + CW'(1) == q.cap) begin
        next_q.mode = FILL_NEVER;
      end
    end
    if (is_psu && fill_mode_wr) begin
      next_q.mode = fill_mode_in;
    end
    if (clr) begin
      next_q.count = '0;
      next_q.wptr = '0;
    end
    next_q.full = (is_psu ? next_q.mode : FILL_ALWAYS) != FILL_ALWAYS
                  && next_q.count == next_q.cap;

    // Source delay setup
    if (sd_wr) begin
      next_q.sd_en = sd_en_in;
      next_q.sd_steps = (sd_steps_in > SD_MAX_STEPS) ? SD_MAX_STEPS : sd_steps_in;
    end
    if (res_wr && (res_in == RES_5P5 || res_in == RES_6P5)) begin
      next_q.sd_en = 1'b1;
      next_q.sd_steps = SD_DEF_STEPS;
    end

    // Source-delay-measure sequence
    case (q.source_delay_measure_cycle)
      SQ_IDLE: begin
        if (sdm_start) begin
          next_q.target = vset_in;
          next_q.sdm_busy = 1'b1;
          next_q.source_delay_measure_cycle = SQ_APPLY;
        end
      end
      SQ_APPLY: begin
        if (q.vset == q.target) begin
          if (is_psu && q.sd_en && q.sd_steps != '0) begin
            next_q.sd_cnt = q.sd_steps;
            next_q.sd_pre = '0;
            next_q.source_delay_measure_cycle = SQ_DELAY;
          end else begin
            next_q.meas_start = 1'b1;
            next_q.sdm_busy = 1'b0;
            next_q.source_delay_measure_cycle = SQ_IDLE;
          end
        end
      end
      SQ_DELAY: begin
        next_q.sd_pre = q.sd_pre + 12'h001;
        if (q.sd_pre == 12'(SD_STEP_CYC - 1)) begin
          next_q.sd_pre = '0;
          next_q.sd_cnt = q.sd_cnt - 24'h000001;
          if (q.sd_cnt == 24'h000001) begin
            next_q.meas_start = 1'b1;
            next_q.sdm_busy = 1'b0;
            next_q.source_delay_measure_cycle = SQ_IDLE;
          end
        end
      end
      default: next_q.source_delay_measure_cycle = SQ_IDLE;
    endcase

    // Delayed output enable and disable
    if (out_req == q.out_en) begin
      next_q.od_pre = '0;
      next_q.od_cnt = '0;
    end else if (!(is_psu && od_en)) begin
      next_q.out_en = out_req;
    end else begin
      od_lim = rbsdm_clamp(out_req ? od_rise_ms : od_fall_ms, OD_MIN_MS, OD_MAX_MS);
      next_q.od_pre = q.od_pre + ODPW'(1);
      if (q.od_pre == ODPW'(OD_CYC - 1)) begin
        next_q.od_pre = '0;
        next_q.od_cnt = q.od_cnt + 14'h0001;
        if (q.od_cnt + 14'h0001 >= od_lim) begin
          next_q.out_en = out_req;
          next_q.od_cnt = '0;
        end
      end
    end

    // Setpoint ramp in the PSU function, one step per microsecond tick; other functions jump straight to the target
    next_q.tick = (q.tick == 8'(SLEW_TICK_CYC - 1)) ? 8'h00 : q.tick + 8'h01;
    if (!is_psu) begin
      next_q.vset = q.target;
    end else if (q.tick == 8'(SLEW_TICK_CYC - 1)) begin
      if (q.vset < q.target) begin
        rate = 10'(rbsdm_clamp(14'(slew_rise), 14'(SLEW_MIN), 14'(SLEW_MAX)));
        diff = q.target - q.vset;
        next_q.vset = (diff > SETW'(rate)) ? q.vset + SETW'(rate) : q.target;
      end else if (q.vset > q.target) begin
        rate = 10'(rbsdm_clamp(14'(slew_fall), 14'(SLEW_MIN), 14'(SLEW_MAX)));
        diff = q.vset - q.target;
        next_q.vset = (diff > SETW'(rate)) ? q.vset - SETW'(rate) : q.target;
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************

  // Control state, reset gives an empty buffer and default settings
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.mode <= FILL_NEVER;
      q.cap_psu <= CAP_PSU_RST;
      q.cap <= CAP_PSU_RST;
      q.sd_en <= 1'b1;
      q.sd_steps <= SD_DEF_STEPS;
      q.source_delay_measure_cycle <= SQ_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Reading store and read port
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      if (accept) begin
        mem[q.wptr] <= {rdg_current, rdg_voltage, rdg_status, q.out_en};
      end
      rd_data <= mem[rd_phys];
    end
  end

  // Outputs straight from state
  assign out_en = q.out_en;
  assign vset_out = q.vset;
  assign meas_start = q.meas_start;
  assign sdm_busy = q.sdm_busy;
  assign fill_mode = q.mode;
  assign buf_count = q.count;
  assign buf_cap = q.cap;
  assign buf_full = q.full;
  assign sd_en = q.sd_en;
  assign sd_steps = q.sd_steps;
  assign stat_avg = st.avg;
  assign stat_min = st.vmin;
  assign stat_max = st.vmax;
  assign stat_p2p = st.p2p;
  assign stat_std = st.std;
  assign stat_busy = st.busy;
endmodule
`default_nettype wire

// ---- rbsdm_top_properties.sv ----
// Checker of buffer, sequencer and output delay behaviour at the top ports
`timescale 1ns/1ps
`default_nettype none
module rbsdm_top_properties #(
  parameter int DEPTH = rbsdm_pkg::CAP_MAX
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] fn_sel,
  input wire logic fill_mode_wr,
  input wire rbsdm_pkg::rbsdm_fill_t fill_mode_in,
  input wire logic auto_clear_en,
  input wire logic buf_clear,
  input wire logic cap_wr,
  input wire logic [11:0] cap_in,
  input wire logic rdg_valid,
  input wire logic sd_wr,
  input wire logic res_wr,
  input wire logic [2:0] res_in,
  input wire logic out_req,
  input wire logic out_en,
  input wire logic meas_start,
  input wire logic sdm_busy,
  input wire rbsdm_pkg::rbsdm_fill_t fill_mode,
  input wire logic [11:0] buf_count,
  input wire logic [11:0] buf_cap,
  input wire logic buf_full,
  input wire logic sd_en,
  input wire logic [23:0] sd_steps
);
  import rbsdm_pkg::*;
  logic [1:0] fn_d;
  logic quiet;
  logic never_eff;
  // ********************************************************************
  // Helper logic
  // ********************************************************************
  // Previous function, so that a function change can be excluded
  always_ff @(posedge mclk) begin
    fn_d <= fn_sel;
  end
  // No clear, capacity or mode event this cycle; effective never mode
  always_comb begin
    quiet = !buf_clear && !cap_wr && !fill_mode_wr && fn_sel == fn_d;
    never_eff = fn_sel == FN_PSU && fill_mode == FILL_NEVER;
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ********************************************************************
  // Assertions
  // ********************************************************************
  AST_NEVER_DROP:
    assert property (rdg_valid && quiet && never_eff |=> buf_count == $past(buf_count))
    else $error("reading stored in never mode");
  AST_COUNT_STEP:
    assert property (rdg_valid && quiet && !never_eff && buf_count < buf_cap
      |=> buf_count == $past(buf_count) + 12'h001)
    else $error("count did not step by one");
  AST_NEXT_STOP:
    assert property (rdg_valid && quiet && fn_sel == FN_PSU && fill_mode == FILL_NEXT
      && buf_count == buf_cap - 12'h001 |=> buf_full && fill_mode == FILL_NEVER)
    else $error("next mode did not stop at capacity");
  AST_WRAP:
    assert property (rdg_valid && quiet && !never_eff
      && !(fn_sel == FN_PSU && fill_mode == FILL_NEXT) && buf_count == buf_cap
      |=> buf_count == buf_cap && !buf_full)
    else $error("circular store reported full or lost count");
  AST_BATT_CAP:
    assert property (fn_sel != FN_PSU && fn_sel == fn_d |=> buf_cap == CAP_BATT)
    else $error("battery capacity not fixed");
  AST_CAP_CLEAR:
    assert property (cap_wr && fn_sel == FN_PSU && cap_in != buf_cap && cap_in != 12'h000
      && cap_in <= DEPTH |=> buf_count == 12'h000 && buf_cap == $past(cap_in))
    else $error("capacity change did not clear");
  AST_AUTOCLEAR:
    assert property (fill_mode_wr && auto_clear_en && fn_sel == FN_PSU
      && fill_mode_in != FILL_NEVER |=> buf_count == 12'h000 && fill_mode == $past(fill_mode_in))
    else $error("autoclear missing on storage start");
  AST_RES_FORCE:
    assert property (res_wr && !sd_wr && (res_in == RES_5P5 || res_in == RES_6P5)
      |=> sd_en && sd_steps == SD_DEF_STEPS)
    else $error("high resolution did not force delay");
  AST_MEAS_END:
    assert property (meas_start |-> $past(sdm_busy) && !sdm_busy ##1 !meas_start)
    else $error("measure start outside a cycle end");
  AST_OUT_DIRECT:
    assert property (fn_sel != FN_PSU && fn_sel == fn_d && out_req != out_en
      |=> out_en == $past(out_req))
    else $error("output delayed in battery function");
  COV_NEXT_FULL: cover property (rdg_valid && fill_mode == FILL_NEXT && buf_count == buf_cap - 12'h001);
  COV_WRAP: cover property (rdg_valid && fill_mode == FILL_ALWAYS && buf_count == buf_cap);
  COV_MEAS: cover property (meas_start);
endmodule
bind rbsdm_top rbsdm_top_properties #(.DEPTH(DEPTH)) u_props (.mclk, .rst, .fn_sel,
  .fill_mode_wr, .fill_mode_in, .auto_clear_en, .buf_clear, .cap_wr, .cap_in, .rdg_valid,
  .sd_wr, .res_wr, .res_in, .out_req, .out_en, .meas_start, .sdm_busy, .fill_mode,
  .buf_count, .buf_cap, .buf_full, .sd_en, .sd_steps);
`default_nettype wire

// ---- rbsdm_frontend.sv ----
// Acquisition front end model: one reading per request or per measurement start
`timescale 1ns/1ps
`default_nettype none
module rbsdm_frontend (
  input wire logic mclk,
  input wire logic rst,
  input wire logic meas_start,
  input wire logic take,
  input wire logic signed [23:0] v_in,
  input wire logic signed [23:0] c_in,
  input wire logic [7:0] st_in,
  output logic rdg_valid,
  output logic signed [23:0] rdg_current,
  output logic signed [23:0] rdg_voltage,
  output logic [7:0] rdg_status
);
  // ********************************************************************
  // Reading launch
  // ********************************************************************
  // One valid cycle per request; idle lines invert every cycle, so stale data matches only on alternate cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdg_valid <= 1'b0;
      rdg_current <= 24'sh0;
      rdg_voltage <= 24'sh0;
      rdg_status <= 8'h00;
    end else begin
      rdg_valid <= take | meas_start;
      if (take | meas_start) begin
        rdg_current <= c_in;
        rdg_voltage <= v_in;
        rdg_status <= st_in;
      end else begin
        rdg_current <= ~rdg_current;
        rdg_voltage <= ~rdg_voltage;
        rdg_status <= ~rdg_status;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rbsdm_top_tb_top.sv ----
// Self-checking testbench for the reading buffer and sequencer
`timescale 1ns/1ps
`default_nettype none
module rbsdm_top_tb_top;
  import rbsdm_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] fn_sel = 2'h0;
  logic fill_mode_wr = 1'b0, auto_clear_en = 1'b1, buf_clear = 1'b0, cap_wr = 1'b0;
  rbsdm_fill_t fill_mode_in = FILL_NEVER;
  logic [11:0] cap_in = 12'h000, rd_idx = 12'h000;
  logic sd_wr = 1'b0, sd_en_in = 1'b0, res_wr = 1'b0, od_en = 1'b0, out_req = 1'b0;
  logic sdm_start = 1'b0, take = 1'b0;
  logic [23:0] sd_steps_in = 24'h000000;
  logic [2:0] res_in = 3'h0;
  logic [13:0] od_rise_ms = 14'h0002, od_fall_ms = 14'h0001;
  logic [9:0] slew_rise = 10'h3e8, slew_fall = 10'h00a;
  logic [24:0] vset_in = 25'h0000000;
  logic signed [23:0] v_in = 24'sh0, c_in = 24'sh0;
  logic [7:0] st_in = 8'h5a;
  logic rdg_valid, out_en, meas_start, sdm_busy, buf_full, sd_en, stat_busy;
  logic signed [23:0] rdg_current, rdg_voltage, stat_avg, stat_min, stat_max;
  logic [7:0] rdg_status;
  logic [56:0] rd_data;
  rbsdm_fill_t fill_mode;
  logic [11:0] buf_count, buf_cap;
  logic [23:0] sd_steps, stat_std;
  logic [24:0] vset_out, stat_p2p;
  int err_total = 0, total_checks = 0, n;
  int vals[5] = '{10, 10, 30, 30, 50};
  rbsdm_top #(.OD_CYC(10)) dut (.mclk, .rst, .fn_sel, .fill_mode_wr, .fill_mode_in,
    .auto_clear_en, .buf_clear, .cap_wr, .cap_in, .rdg_valid, .rdg_current, .rdg_voltage,
    .rdg_status, .rd_idx, .rd_data, .sd_wr, .sd_en_in, .sd_steps_in, .res_wr, .res_in, .od_en,
    .od_rise_ms, .od_fall_ms, .out_req, .slew_rise, .slew_fall, .vset_in, .sdm_start, .out_en,
    .vset_out, .meas_start, .sdm_busy, .fill_mode, .buf_count, .buf_cap, .buf_full, .sd_en,
    .sd_steps, .stat_avg, .stat_min, .stat_max, .stat_p2p, .stat_std, .stat_busy);
  rbsdm_frontend fe (.mclk, .rst, .meas_start, .take, .v_in, .c_in, .st_in, .rdg_valid,
    .rdg_current, .rdg_voltage, .rdg_status);
  // ********************************************************************
  // Clock and tasks
  // ********************************************************************
  // Free running 250 MHz clock
  always #2 mclk = ~mclk;
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic rdg(input int v);
    @(posedge mclk);
    take <= 1'b1;
    v_in <= 24'(v);
    c_in <= 24'(v + 1);
    @(posedge mclk);
    take <= 1'b0;
  endtask
  task automatic set_mode(input rbsdm_fill_t m);
    @(posedge mclk);
    fill_mode_in <= m;
    fill_mode_wr <= 1'b1;
    @(posedge mclk);
    fill_mode_wr <= 1'b0;
  endtask
  task automatic set_cap(input logic [11:0] c);
    @(posedge mclk);
    cap_in <= c;
    cap_wr <= 1'b1;
    @(posedge mclk);
    cap_wr <= 1'b0;
  endtask
  task automatic set_sd(input logic e, input logic [23:0] s);
    @(posedge mclk);
    sd_en_in <= e;
    sd_steps_in <= s;
    sd_wr <= 1'b1;
    @(posedge mclk);
    sd_wr <= 1'b0;
  endtask
  task automatic set_res(input logic [2:0] r);
    @(posedge mclk);
    res_in <= r;
    res_wr <= 1'b1;
    @(posedge mclk);
    res_wr <= 1'b0;
  endtask
  // Start a cycle and count edges until the measurement begins
  task automatic run_sdm(output int k);
    @(posedge mclk);
    sdm_start <= 1'b1;
    @(posedge mclk);
    sdm_start <= 1'b0;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (meas_start !== 1'b1 && k < 5000);
  endtask
  task automatic stat_wait;
    tick(2);
    n = 0;
    while (stat_busy !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ********************************************************************
  // Tests
  // ********************************************************************
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk(buf_cap, CAP_PSU_RST);
    chk({buf_count, fill_mode}, {12'h000, FILL_NEVER});
    chk({sd_en, sd_steps}, {1'b1, SD_DEF_STEPS});
    for (int i = 0; i < 3; i++) rdg(i);
    tick(2);
    chk(buf_count, 0);
    set_cap(12'h004);
    set_mode(FILL_NEXT);
    foreach (vals[i]) rdg(vals[i]);
    tick(2);
    chk(buf_count, 4);
    chk({buf_full, fill_mode}, {1'b1, FILL_NEVER});
    chk(rd_data, {24'h00000b, 24'h00000a, 8'h5a, 1'b0});
    stat_wait();
    chk({stat_avg, stat_min, stat_max}, {24'h000014, 24'h00000a, 24'h00001e});
    chk({stat_p2p, stat_std}, {25'h0000014, 24'h00000a});
    set_cap(12'h005);
    tick(2);
    chk(buf_count, 0);
    stat_wait();
    chk(stat_max, 0);
    set_mode(FILL_ALWAYS);
    for (int i = 1; i < 8; i++) rdg(i);
    tick(3);
    chk({buf_full, buf_count}, {1'b0, 12'h005});
    chk(rd_data[32:9], 3);
    @(posedge mclk) rd_idx <= 12'h004;
    tick(2);
    chk(rd_data[32:9], 7);
    set_mode(FILL_NEVER);
    @(posedge mclk) fn_sel <= FN_BTEST;
    tick(3);
    chk({buf_cap, buf_count}, {CAP_BATT, 12'h000});
    set_cap(12'h007);
    tick(2);
    chk(buf_cap, CAP_BATT);
    rdg(4);
    rdg(8);
    tick(2);
    chk(buf_count, 2);
    @(posedge mclk) vset_in <= 25'd1000;
    run_sdm(n);
    chk({n <= 3, vset_out}, {1'b1, 25'd1000});
    tick(2);
    chk(buf_count, 3);
    stat_wait();
    chk(stat_avg, 6);
    @(posedge mclk) fn_sel <= FN_PSU;
    tick(3);
    set_sd(1'b1, 24'h000001);
    run_sdm(n);
    chk(n >= 2500 && n <= 2510, 1);
    set_sd(1'b0, 24'h000000);
    @(posedge mclk) vset_in <= 25'd11000;
    run_sdm(n);
    chk({n > 2240 && n < 2760, vset_out}, {1'b1, 25'd11000});
    @(posedge mclk) vset_in <= 25'd10900;
    run_sdm(n);
    chk({n > 2240 && n < 2760, vset_out}, {1'b1, 25'd10900});
    for (int i = 0; i < 2; i++) begin
      set_sd(1'b0, 24'h000005);
      set_res(RES_5P5 + 3'(i));
      tick(2);
      chk({sd_en, sd_steps}, {1'b1, SD_DEF_STEPS});
    end
    @(posedge mclk) od_en <= 1'b1;
    @(posedge mclk) out_req <= 1'b1;
    tick(15);
    chk(out_en, 0);
    tick(10);
    chk(out_en, 1);
    @(posedge mclk) out_req <= 1'b0;
    tick(5);
    chk(out_en, 1);
    tick(10);
    chk(out_en, 0);
    @(posedge mclk) fn_sel <= FN_BSIM;
    tick(3);
    @(posedge mclk) out_req <= 1'b1;
    tick(2);
    chk(out_en, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
